// ==== src/bbc_map.svh ====
`ifndef BBC_MAP_SVH
`define BBC_MAP_SVH

// ----------------------------------------------------------------
// beat operation select encodings
// ----------------------------------------------------------------
`define BBC_OP_HOLD        2'h0
`define BBC_OP_DECR        2'h1
`define BBC_OP_LOAD        2'h2
`define BBC_OP_SPARE       2'h3

// ----------------------------------------------------------------
// counter values
// ----------------------------------------------------------------
`define BBC_COUNT_RST      2'h0
`define BBC_COUNT_ZERO     2'h0
`define BBC_COUNT_STEP     2'h1
`define BBC_FULL_BLOCK     2'h3

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BBC_REG_CTRL       4'h0
`define BBC_REG_STATUS     4'h4
`define BBC_REG_LOADS      4'h8
`define BBC_REG_WRAPS      4'hC

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BBC_CTRL_FLAG_EN   0
`define BBC_CTRL_RST       1'h1
`define BBC_ST_COUNT_LSB   0
`define BBC_ST_ZERO        2
`define BBC_ST_DRAM        3
`define BBC_ST_OP_LSB      4
`define BBC_ST_WRITE       6
`define BBC_EVT_RST        16'h0000
`define BBC_EVT_ONE        16'h0001

`endif

// ==== src/bbc_pkg.sv ====
`include "bbc_map.svh"

package bbc_pkg;
	typedef enum logic [1:0] {
		BBC_HOLD  = `BBC_OP_HOLD,
		BBC_DECR  = `BBC_OP_DECR,
		BBC_LOAD  = `BBC_OP_LOAD,
		BBC_SPARE = `BBC_OP_SPARE
	} bbc_op_e;

	typedef logic [1:0]  bbc_count_t;
	typedef logic [15:0] bbc_evt_t;
endpackage

// ==== src/bbc_beat_if.sv ====
`timescale 1ns/10ps

interface bbc_beat_if;
	bbc_pkg::bbc_op_e   op;
	logic               line_fill;
	logic [1:0]         word_addr;
	bbc_pkg::bbc_count_t count;
	bbc_pkg::bbc_count_t count_next;
	logic               zero_next;

	modport core (
		input  op,
		input  line_fill,
		input  word_addr,
		input  count,
		output count_next,
		output zero_next
	);

	modport ctrl (
		output op,
		output line_fill,
		output word_addr,
		output count,
		input  count_next,
		input  zero_next
	);
endinterface

// ==== src/bbc_beat_next.sv ====
`timescale 1ns/10ps
`include "bbc_map.svh"

module bbc_beat_next (
	// operation, inputs and present count
	bbc_beat_if.core beat
);
	// ----------------------------------------------------------------
	// load value
	// ----------------------------------------------------------------
	// line fill forces a whole block, else room left to the boundary
	function automatic logic [1:0] load_value(input logic fill, input logic [1:0] addr);
		load_value = fill ? `BBC_FULL_BLOCK : ~addr;
	endfunction

	// ----------------------------------------------------------------
	// next count
	// ----------------------------------------------------------------
	wire is_load = (beat.op == bbc_pkg::BBC_LOAD);
	wire is_decr = (beat.op == bbc_pkg::BBC_DECR);
	// fill hint used raw in this cycle, no earlier sampling needed
	wire [1:0] load_val = load_value(beat.line_fill, beat.word_addr);
	// wraps 0 to 3 by plain 2-bit arithmetic
	wire [1:0] decr_val = beat.count - `BBC_COUNT_STEP;

	// spare encoding falls through to hold
	assign beat.count_next = is_load ? load_val : (is_decr ? decr_val : beat.count);
	assign beat.zero_next  = (beat.count_next == `BBC_COUNT_ZERO);
endmodule

// ==== src/bbc_top.sv ====
`timescale 1ns/10ps
`include "bbc_map.svh"

// How it works
// - a 2-bit beat counter driven by main control, seen by main and DRAM machines
// - two-bit select gives hold, decrement or request load; idle select holds
// - decrement subtracts one; decrement at zero wraps to three
// - without line fill, load stores inverse of the two low word-address bits
// - with line fill, load stores three whatever the low address bits
// - zero is reported to the main machine for SSRAM, DRAM machine for BEDO
// - count updates on the clock edge after the select is presented
// - line fill hint feeds the load directly in the load cycle
module bbc_top (
	// clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_B_I,
	// beat control from main state machine
	input  wire logic [1:0]  BEAT_OP_I,
	input  wire logic        LINE_FILL_I,
	input  wire logic        CPU_WRITE_I,
	input  wire logic [1:0]  WORD_ADDR_I,
	input  wire logic        DRAM_XFER_I,
	// register port
	input  wire logic [3:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [31:0] REG_RDATA_O,
	// count and boundary flags
	output logic      [1:0]  BEAT_COUNT_O,
	output logic             BEAT_ZERO_O,
	output logic             SSRAM_BOUNDARY_O,
	output logic             DRAM_BOUNDARY_O
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bbc_pkg::bbc_count_t count_q;
	logic                zero_q;
	logic                dram_sel_q;
	logic                dram_sel_d;
	logic                wrote_q;
	logic                wrote_d;
	bbc_pkg::bbc_op_e    last_op_q;
	logic                flag_en_q;
	bbc_pkg::bbc_evt_t   loads_q;
	bbc_pkg::bbc_evt_t   loads_d;
	bbc_pkg::bbc_evt_t   wraps_q;
	bbc_pkg::bbc_evt_t   wraps_d;
	logic                ssram_bnd_d;
	logic                dram_bnd_d;
	logic                ssram_bnd_q;
	logic                dram_bnd_q;
	logic [31:0]         rdata_d;
	logic [31:0]         rdata_q;
	logic [31:0]         status_w;

	// ----------------------------------------------------------------
	// next-count logic
	// ----------------------------------------------------------------
	bbc_beat_if beat ();

	assign beat.op        = bbc_pkg::bbc_op_e'(BEAT_OP_I);
	assign beat.line_fill = LINE_FILL_I;
	assign beat.word_addr = WORD_ADDR_I;
	assign beat.count     = count_q;

	bbc_beat_next u_next (
		.beat (beat.core)
	);

	// ----------------------------------------------------------------
	// op decode
	// ----------------------------------------------------------------
	wire op_load  = (BEAT_OP_I == `BBC_OP_LOAD);
	wire op_decr  = (BEAT_OP_I == `BBC_OP_DECR);
	// a decrement from zero starts the next block
	wire wrap_evt = op_decr && (count_q == `BBC_COUNT_ZERO);

	// target memory is latched with the load, held for the transfer
	assign dram_sel_d = op_load ? DRAM_XFER_I : dram_sel_q;
	assign wrote_d    = op_load ? CPU_WRITE_I : wrote_q;

	// zero routed to the machine that owns the current target
	assign ssram_bnd_d = flag_en_q && beat.zero_next && !dram_sel_d;
	assign dram_bnd_d  = flag_en_q && beat.zero_next && dram_sel_d;

	// ----------------------------------------------------------------
	// counter registers
	// ----------------------------------------------------------------
	// one edge from select to new count; outputs stay flop driven
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			count_q <= `BBC_COUNT_RST;
			zero_q  <= 1'h1;
		end else begin
			count_q <= beat.count_next;
			zero_q  <= beat.zero_next;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dram_sel_q  <= 1'h0;
			wrote_q     <= 1'h0;
			last_op_q   <= bbc_pkg::BBC_HOLD;
			ssram_bnd_q <= 1'h0;
			dram_bnd_q  <= 1'h0;
		end else begin
			dram_sel_q  <= dram_sel_d;
			wrote_q     <= wrote_d;
			last_op_q   <= bbc_pkg::bbc_op_e'(BEAT_OP_I);
			ssram_bnd_q <= ssram_bnd_d;
			dram_bnd_q  <= dram_bnd_d;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire hit_ctrl   = (REG_ADDR_I == `BBC_REG_CTRL);
	wire hit_status = (REG_ADDR_I == `BBC_REG_STATUS);
	wire hit_loads  = (REG_ADDR_I == `BBC_REG_LOADS);
	wire hit_wraps  = (REG_ADDR_I == `BBC_REG_WRAPS);

	wire wr_ctrl  = REG_WR_I && hit_ctrl;
	wire clr_load = REG_WR_I && hit_loads;
	wire clr_wrap = REG_WR_I && hit_wraps;

	// clear and event together leave one: the event is not lost
	assign loads_d = clr_load ? (op_load ? `BBC_EVT_ONE : `BBC_EVT_RST)
	                          : (op_load ? loads_q + `BBC_EVT_ONE : loads_q);
	assign wraps_d = clr_wrap ? (wrap_evt ? `BBC_EVT_ONE : `BBC_EVT_RST)
	                          : (wrap_evt ? wraps_q + `BBC_EVT_ONE : wraps_q);

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`BBC_ST_COUNT_LSB +: 2] = count_q;
		status_w[`BBC_ST_ZERO]           = zero_q;
		status_w[`BBC_ST_DRAM]           = dram_sel_q;
		status_w[`BBC_ST_OP_LSB +: 2]    = last_op_q;
		status_w[`BBC_ST_WRITE]          = wrote_q;
	end

	// unmapped offsets read zero; data only in the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (REG_RD_I && hit_ctrl) begin
			rdata_d[`BBC_CTRL_FLAG_EN] = flag_en_q;
		end else if (REG_RD_I && hit_status) begin
			rdata_d = status_w;
		end else if (REG_RD_I && hit_loads) begin
			rdata_d = {16'h0000, loads_q};
		end else if (REG_RD_I && hit_wraps) begin
			rdata_d = {16'h0000, wraps_q};
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			flag_en_q <= `BBC_CTRL_RST;
			loads_q   <= `BBC_EVT_RST;
			wraps_q   <= `BBC_EVT_RST;
			rdata_q   <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) begin
				flag_en_q <= REG_WDATA_I[`BBC_CTRL_FLAG_EN];
			end
			loads_q <= loads_d;
			wraps_q <= wraps_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign REG_RDATA_O      = rdata_q;
	assign BEAT_COUNT_O     = count_q;
	assign BEAT_ZERO_O      = zero_q;
	assign SSRAM_BOUNDARY_O = ssram_bnd_q;
	assign DRAM_BOUNDARY_O  = dram_bnd_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking chk_clk @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_B_I);

	hold_keeps_a: assert property (
		(BEAT_OP_I == `BBC_OP_HOLD) |=> $stable(BEAT_COUNT_O)
	) else $error("count moved on hold");

	spare_holds_a: assert property (
		(BEAT_OP_I == `BBC_OP_SPARE) |=> $stable(BEAT_COUNT_O)
	) else $error("count moved on spare select");

	decr_step_a: assert property (
		op_decr && (BEAT_COUNT_O != `BBC_COUNT_ZERO)
		|=> BEAT_COUNT_O == $past(BEAT_COUNT_O) - `BBC_COUNT_STEP
	) else $error("decrement did not step by one");

	decr_wrap_a: assert property (
		wrap_evt |=> (BEAT_COUNT_O == `BBC_FULL_BLOCK) && !BEAT_ZERO_O
	) else $error("decrement at zero did not wrap to three");

	load_partial_a: assert property (
		op_load && !LINE_FILL_I |=> BEAT_COUNT_O == ~$past(WORD_ADDR_I)
	) else $error("partial load value wrong");

	load_fill_a: assert property (
		op_load && LINE_FILL_I |=> BEAT_COUNT_O == `BBC_FULL_BLOCK
	) else $error("line fill load not three");

	zero_track_a: assert property (
		BEAT_ZERO_O == (BEAT_COUNT_O == `BBC_COUNT_ZERO)
	) else $error("zero flag disagrees with count");

	change_cause_a: assert property (
		!$stable(BEAT_COUNT_O) |-> $past(op_load) || $past(op_decr)
	) else $error("count changed without select");

	ssram_route_a: assert property (
		SSRAM_BOUNDARY_O |-> BEAT_ZERO_O && !dram_sel_q && !DRAM_BOUNDARY_O
	) else $error("SSRAM boundary flag misrouted");

	dram_route_a: assert property (
		op_load && DRAM_XFER_I && flag_en_q ##1 (op_decr && !op_load) [*3]
		|=> DRAM_BOUNDARY_O == BEAT_ZERO_O
	) else $error("DRAM boundary flag misrouted");

	read_slot_a: assert property (
		!REG_RD_I |=> REG_RDATA_O == 32'h0000_0000
	) else $error("read data outside answer cycle");

	dram_only_a: assert property (
		DRAM_BOUNDARY_O |-> BEAT_ZERO_O && dram_sel_q && !SSRAM_BOUNDARY_O
	) else $error("DRAM boundary flag outside DRAM zero");

	bnd_enable_a: assert property (
		!flag_en_q |=> !SSRAM_BOUNDARY_O && !DRAM_BOUNDARY_O
	) else $error("boundary flag raised while disabled");

	bnd_present_a: assert property (
		flag_en_q && beat.zero_next |=> SSRAM_BOUNDARY_O || DRAM_BOUNDARY_O
	) else $error("zero count raised no boundary flag");

	target_latch_a: assert property (
		op_load |=> dram_sel_q == $past(DRAM_XFER_I)
	) else $error("target not taken on load");

	target_keep_a: assert property (
		!op_load |=> $stable(dram_sel_q)
	) else $error("target changed without load");

	write_latch_a: assert property (
		op_load |=> wrote_q == $past(CPU_WRITE_I)
	) else $error("write flag not taken on load");

	load_tally_a: assert property (
		op_load && !clr_load |=> loads_q == $past(loads_q) + `BBC_EVT_ONE
	) else $error("load counter missed a load");

	wrap_tally_a: assert property (
		wrap_evt && !clr_wrap |=> wraps_q == $past(wraps_q) + `BBC_EVT_ONE
	) else $error("wrap counter missed a wrap");

	wrap_clear_a: assert property (
		clr_wrap && !wrap_evt |=> wraps_q == `BBC_EVT_RST
	) else $error("wrap counter not cleared");

	ctrl_write_a: assert property (
		wr_ctrl |=> flag_en_q == $past(REG_WDATA_I[`BBC_CTRL_FLAG_EN])
	) else $error("flag enable write lost");

	status_read_a: assert property (
		REG_RD_I && hit_status |=> REG_RDATA_O == $past(status_w)
	) else $error("status read data wrong");

	loads_read_a: assert property (
		REG_RD_I && hit_loads |=> REG_RDATA_O == {16'h0000, $past(loads_q)}
	) else $error("load counter read data wrong");

	block_burst_c: cover property (
		op_load && LINE_FILL_I ##1 op_decr [*4] ##1 BEAT_COUNT_O == `BBC_FULL_BLOCK
	);

	wrap_c: cover property (wrap_evt);

	dram_bnd_c: cover property (DRAM_BOUNDARY_O);

	dram_burst_c: cover property (op_load && DRAM_XFER_I ##1 op_decr [*3]);

	status_read_c: cover property (REG_RD_I && hit_status ##1 REG_RDATA_O != 32'h0000_0000);
endmodule

// ==== verif/bbc_ctrl_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// controller stand-in: one load, then one decrement per beat
// ----------------------------------------------------------------
module bbc_ctrl_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// burst request and idle op from bench
	input  wire logic       start_i,
	input  wire logic [3:0] beats_i,
	input  wire logic [1:0] gap_i,
	input  wire logic [1:0] direct_op_i,
	// beat control towards the block
	output logic      [1:0] op_o,
	output logic            busy_o
);
	logic [3:0] left_q;
	logic [1:0] wait_q;
	logic       load_q;
	wire        beat_due = (left_q != 4'h0) && (wait_q == 2'h0);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_q <= 4'h0;
			wait_q <= 2'h0;
			load_q <= 1'b0;
		end else if (start_i && !busy_o) begin
			left_q <= beats_i;
			wait_q <= gap_i;
			load_q <= 1'b1;
		end else if (load_q) begin
			load_q <= 1'b0;
		end else if (beat_due) begin
			left_q <= left_q - 4'h1;
			wait_q <= gap_i;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end
	end

	assign busy_o = load_q || (left_q != 4'h0);
	// never reloads mid-burst: a zero count is just decremented on to three
	assign op_o = load_q ? bbc_pkg::BBC_LOAD : beat_due ? bbc_pkg::BBC_DECR :
		busy_o ? bbc_pkg::BBC_HOLD : direct_op_i;
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps

module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic [3:0]  beats = 4'h0;
	logic [1:0]  gap = 2'h0;
	logic [1:0]  direct_op = 2'h0;
	logic        fill = 1'b0;
	logic        cpu_write = 1'b0;
	logic [1:0]  addr = 2'h0;
	logic        dram = 1'b0;
	logic [3:0]  raddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [1:0]  op;
	logic        busy;
	logic [1:0]  cnt;
	logic        zero;
	logic        sflag;
	logic        dflag;
	int          n_errors = 0;
	int          total_checks = 0;
	int          exp_wraps = 0;
	int          i;

	always #2.5 clk = ~clk;

	bbc_ctrl_model ctrl (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .beats_i(beats),
		.gap_i(gap), .direct_op_i(direct_op), .op_o(op), .busy_o(busy));

	bbc_top dut (.CLK_SYS_I(clk), .RST_B_I(rst_n), .BEAT_OP_I(op), .LINE_FILL_I(fill),
		.CPU_WRITE_I(cpu_write), .WORD_ADDR_I(addr), .DRAM_XFER_I(dram),
		.REG_ADDR_I(raddr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .BEAT_COUNT_O(cnt), .BEAT_ZERO_O(zero),
		.SSRAM_BOUNDARY_O(sflag), .DRAM_BOUNDARY_O(dflag));

	// ----------------------------------------------------------------
	// check and access tasks
	// ----------------------------------------------------------------
	task automatic conclude;
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_beat(input logic [1:0] c, input logic s, input logic d);
		chk("count", {30'h0, c}, {30'h0, cnt});
		chk("zero", {31'h0, c == 2'h0}, {31'h0, zero});
		chk("ssram flag", {31'h0, s}, {31'h0, sflag});
		chk("dram flag", {31'h0, d}, {31'h0, dflag});
	endtask

	task automatic do_op(input logic [1:0] o);
		@(posedge clk) direct_op <= o;
		@(posedge clk) direct_op <= 2'h0;
		#1;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		raddr <= a;
		wdata <= d;
		@(posedge clk) wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		rd <= 1'b1;
		raddr <= a;
		@(posedge clk) rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask

	// runs a burst through the controller and returns the expected end count
	task automatic burst(input logic [3:0] b, input logic [1:0] g, input logic f,
		input logic [1:0] a, input logic d, output logic [1:0] c);
		int k;
		@(posedge clk);
		start <= 1'b1;
		beats <= b;
		gap <= g;
		fill <= f;
		addr <= a;
		dram <= d;
		@(posedge clk) start <= 1'b0;
		c = f ? 2'h3 : ~a;
		for (k = 0; k < int'(b); k++) begin
			if (c == 2'h0) exp_wraps++;
			c = c - 2'h1;
		end
		#1;
		k = 0;
		while (busy) begin
			if (k == 200) begin
				n_errors++;
				conclude();
			end
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [1:0] e;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk_beat(2'h0, 1'b1, 1'b0);
		reg_rd(4'h0, 32'h1, "ctrl");
		reg_rd(4'h4, 32'h4, "status");
		reg_rd(4'h8, 32'h0, "loads");
		reg_rd(4'hC, 32'h0, "wraps");
		reg_rd(4'h2, 32'h0, "unmapped");
		// every fill, write and address combination through a load
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			fill <= i[3];
			cpu_write <= i[2];
			addr <= i[1:0];
			e = i[3] ? 2'h3 : ~i[1:0];
			do_op(2'h2);
			chk_beat(e, e == 2'h0, 1'b0);
			do_op(2'h3);
			chk_beat(e, e == 2'h0, 1'b0);
			do_op(2'h0);
			chk_beat(e, e == 2'h0, 1'b0);
		end
		reg_rd(4'h8, 32'h10, "loads");
		reg_rd(4'h4, 32'h43, "status");
		reg_wr(4'h4, 32'hFF);
		reg_wr(4'h6, 32'hFF);
		reg_rd(4'h4, 32'h43, "status");
		// walk down through zero and wrap
		for (i = 2; i >= -1; i--) begin
			e = 2'(i);
			do_op(2'h1);
			chk_beat(e, e == 2'h0, 1'b0);
		end
		reg_rd(4'hC, 32'h1, "wraps");
		reg_wr(4'hC, 32'h0);
		reg_rd(4'hC, 32'h0, "wraps");
		// controller bursts, slow then back to back
		burst(4'h7, 2'h2, 1'b0, 2'h0, 1'b1, e);
		chk_beat(e, 1'b0, 1'b1);
		reg_wr(4'h0, 32'h0);
		@(posedge clk);
		#1;
		chk_beat(e, 1'b0, 1'b0);
		reg_wr(4'h0, 32'h1);
		burst(4'h8, 2'h0, 1'b1, 2'h1, 1'b0, e);
		chk_beat(e, 1'b0, 1'b0);
		reg_rd(4'hC, 32'(exp_wraps), "wraps");
		reg_rd(4'h8, 32'h12, "loads");
		// back to back DRAM burst ending on a block boundary
		burst(4'h3, 2'h0, 1'b0, 2'h0, 1'b1, e);
		chk_beat(e, 1'b0, 1'b1);
		conclude();
	end
endmodule
